/* hdl/silp_core.sv */
// Interrupt status, break handling, low-power sequencing and reset causes.
// Assumes irq_req and break_req are synchronous to mclk; resets are latched outside.
`timescale 1ns/1ps
`default_nettype none
module silp_core #(
  parameter int LONG_CYCLES = silp_pkg::LONG_RECOVERY,
  parameter int SHORT_CYCLES = silp_pkg::SHORT_RECOVERY
) (
  input wire logic mclk,
  input wire logic srst,
  input wire silp_pkg::silp_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [silp_pkg::IRQ_COUNT-1:0] irq_req,
  input wire logic break_req,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic reset_event,
  input wire silp_pkg::silp_rst_cause_s reset_cause_in,
  input wire logic short_stop_recovery,
  input wire logic oscillator_run_in_stop,
  input wire logic watchdog_disable,
  input wire logic two_step_first,
  input wire logic two_step_second,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic clear_irq_mask,
  output logic force_swi_vector,
  output logic stacking_start,
  output logic flag_clear_allow,
  output logic two_step_clear,
  output logic watchdog_run,
  output logic [silp_pkg::CNT_W-1:0] recovery_count
);
  // ==========================================
  // Register port decode
  logic rd_cause;
  logic wr_bfc;
  logic in_break;
  logic break_clear_enable_ff;
  logic break_wake_flag_ff;
  silp_pkg::silp_rst_cause_s cause_ff;
  silp_pkg::silp_pmode_e pmode_ff;
  logic [silp_pkg::CNT_W-1:0] cnt_ff;
  logic [silp_pkg::CNT_W-1:0] target_ff;
  logic two_step_armed_ff;
  logic [7:0] nxt_rdata;
  logic wake;
  logic recover_done;
  logic exit_by_reset_ff;

  assign rd_cause = reg_req.sel && !reg_req.wr && reg_req.addr == silp_pkg::ADDR_RESET_CAUSE;
  assign wr_bfc = reg_req.sel && reg_req.wr && reg_req.addr == silp_pkg::ADDR_BREAK_FLAG_CTRL;
  assign wake = |irq_req || break_req;

  // ==========================================
  // Read data; status registers have no write path
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_req.addr)
      silp_pkg::ADDR_BREAK_STATUS:
        nxt_rdata[silp_pkg::BREAK_WAKE_BIT] = break_wake_flag_ff;
      silp_pkg::ADDR_RESET_CAUSE: begin
        nxt_rdata[silp_pkg::RC_POR] = cause_ff.por;
        nxt_rdata[silp_pkg::RC_PIN] = cause_ff.pin;
        nxt_rdata[silp_pkg::RC_WDOG] = cause_ff.wdog;
        nxt_rdata[silp_pkg::RC_OPCODE] = cause_ff.bad_opcode;
        nxt_rdata[silp_pkg::RC_ADDR] = cause_ff.bad_fetch;
        nxt_rdata[silp_pkg::RC_MONITOR] = cause_ff.monitor;
        nxt_rdata[silp_pkg::RC_LVI] = cause_ff.low_voltage;
      end
      silp_pkg::ADDR_BREAK_FLAG_CTRL:
        nxt_rdata[silp_pkg::BREAK_CLEAR_EN_BIT] = break_clear_enable_ff;
      silp_pkg::ADDR_IRQ_STATUS_1:
        nxt_rdata = {irq_req[5:0], 2'b00};
      silp_pkg::ADDR_IRQ_STATUS_2:
        nxt_rdata = irq_req[13:6];
      silp_pkg::ADDR_IRQ_STATUS_3:
        nxt_rdata = {6'h00, irq_req[15:14]};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  // ==========================================
  // Break clear enable
  always_ff @(posedge mclk) begin
    if (srst) begin
      break_clear_enable_ff <= 1'b0;
    end else if (wr_bfc) begin
      break_clear_enable_ff <= reg_req.wdata[silp_pkg::BREAK_CLEAR_EN_BIT];
    end
  end

  // ==========================================
  // Reset cause register, set wins over read clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      cause_ff <= '0;
    end else if (reset_event && reset_cause_in.por) begin
      cause_ff <= reset_cause_in;
    end else if (reset_event) begin
      cause_ff <= (rd_cause ? '0 : cause_ff) | reset_cause_in;
    end else if (rd_cause) begin
      cause_ff <= '0;
    end
  end

  // ==========================================
  // Break state and flag protection
  assign in_break = break_req && !reset_event;
  assign force_swi_vector = in_break;
  assign flag_clear_allow = !in_break || break_clear_enable_ff;

  always_ff @(posedge mclk) begin
    if (srst) begin
      two_step_armed_ff <= 1'b0;
    end else if (two_step_first) begin
      two_step_armed_ff <= 1'b1;
    end else if (two_step_clear) begin
      two_step_armed_ff <= 1'b0;
    end
  end
  assign two_step_clear = two_step_armed_ff && two_step_second && flag_clear_allow;

  // ==========================================
  // Low-power sequencing
  always_ff @(posedge mclk) begin
    if (srst) begin
      pmode_ff <= silp_pkg::PM_RUN;
      cnt_ff <= '0;
      target_ff <= '0;
    end else begin
      unique case (pmode_ff)
        silp_pkg::PM_RUN: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (stop_exec) begin
            pmode_ff <= silp_pkg::PM_STOP;
            cnt_ff <= '0;
          end else if (wait_exec) begin
            pmode_ff <= silp_pkg::PM_WAIT;
          end
        end
        silp_pkg::PM_WAIT: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (wake || reset_event) begin
            pmode_ff <= silp_pkg::PM_RUN;
          end
        end
        silp_pkg::PM_STOP: begin
          cnt_ff <= '0;
          if (reset_event) begin
            pmode_ff <= silp_pkg::PM_RECOVER;
            target_ff <= silp_pkg::CNT_W'(LONG_CYCLES);
          end else if (wake) begin
            pmode_ff <= silp_pkg::PM_RECOVER;
            target_ff <= short_stop_recovery ? silp_pkg::CNT_W'(SHORT_CYCLES)
                                             : silp_pkg::CNT_W'(LONG_CYCLES);
          end
        end
        silp_pkg::PM_RECOVER: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == target_ff - 1'b1) begin
            pmode_ff <= silp_pkg::PM_RUN;
          end
        end
      endcase
    end
  end

  assign recovery_count = cnt_ff;
  assign clear_irq_mask = wait_exec || stop_exec;
  assign cpu_clk_en = pmode_ff == silp_pkg::PM_RUN && !wait_exec && !stop_exec;
  assign periph_clk_en = pmode_ff == silp_pkg::PM_RUN || pmode_ff == silp_pkg::PM_WAIT;
  assign osc_en = pmode_ff != silp_pkg::PM_STOP || oscillator_run_in_stop;
  assign watchdog_run = !watchdog_disable && pmode_ff != silp_pkg::PM_STOP;
  assign recover_done = pmode_ff == silp_pkg::PM_RECOVER && cnt_ff == target_ff - 1'b1;
  assign stacking_start = !reset_event && ((pmode_ff == silp_pkg::PM_WAIT && |irq_req)
    || (recover_done && !exit_by_reset_ff));

  // ==========================================
  // Stop exit cause; a reset exit stacks nothing
  always_ff @(posedge mclk) begin
    if (srst) begin
      exit_by_reset_ff <= 1'b0;
    end else if (pmode_ff == silp_pkg::PM_STOP && reset_event) begin
      exit_by_reset_ff <= 1'b1;
    end else if (pmode_ff == silp_pkg::PM_STOP && wake) begin
      exit_by_reset_ff <= 1'b0;
    end
  end

  // ==========================================
  // Break wake flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      break_wake_flag_ff <= 1'b0;
    end else if (pmode_ff == silp_pkg::PM_WAIT && break_req) begin
      break_wake_flag_ff <= 1'b1;
    end else if (pmode_ff == silp_pkg::PM_WAIT && wake) begin
      break_wake_flag_ff <= 1'b0;
    end
  end

  // ==========================================
  // Checks
  irq_map_a: assert property (@(posedge mclk) disable iff (srst)
    reg_req.addr == silp_pkg::ADDR_IRQ_STATUS_3 |=> reg_rdata[7:2] == 6'h00)
    else $error("irq status 3 upper bits not zero");
  low_bits_a: assert property (@(posedge mclk) disable iff (srst)
    reg_req.addr == silp_pkg::ADDR_IRQ_STATUS_1 |=> reg_rdata[1:0] == 2'b00)
    else $error("irq status 1 low bits not zero");
  flag_track_a: assert property (@(posedge mclk) disable iff (srst)
    reg_req.addr == silp_pkg::ADDR_IRQ_STATUS_2 |=> reg_rdata == $past(irq_req[13:6]))
    else $error("irq status 2 does not track requests");
  cause_clear_a: assert property (@(posedge mclk) disable iff (srst)
    rd_cause && !reset_event |=> cause_ff == '0)
    else $error("reset cause not cleared by read");
  por_only_a: assert property (@(posedge mclk) disable iff (srst)
    reset_event && reset_cause_in.por |=> cause_ff == $past(reset_cause_in))
    else $error("power-on did not clear other causes");
  stop_hold_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_STOP |=> cnt_ff == '0)
    else $error("counter not held in stop");
  reset_long_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_STOP && reset_event
    |=> target_ff == silp_pkg::CNT_W'(LONG_CYCLES))
    else $error("reset stop exit not long");
  recover_clk_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_RECOVER |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks active during recovery");
  break_prot_a: assert property (@(posedge mclk) disable iff (srst)
    in_break && !break_clear_enable_ff |-> !flag_clear_allow && !two_step_clear)
    else $error("flag clear allowed in protected break");
  mask_clr_a: assert property (@(posedge mclk) disable iff (srst)
    stop_exec |-> clear_irq_mask && !cpu_clk_en)
    else $error("low-power entry did not gate clock");

  swi_force_a: assert property (@(posedge mclk) disable iff (srst)
    break_req && !reset_event
    |-> force_swi_vector)
    else $error("break did not force software interrupt vector");

  reset_prio_a: assert property (@(posedge mclk) disable iff (srst)
    reset_event
    |-> !force_swi_vector && !stacking_start)
    else $error("interrupt activity during reset");

  break_open_a: assert property (@(posedge mclk) disable iff (srst)
    in_break && break_clear_enable_ff
    |-> flag_clear_allow)
    else $error("enabled clear blocked in break");

  run_clear_a: assert property (@(posedge mclk) disable iff (srst)
    !in_break
    |-> flag_clear_allow)
    else $error("flag clear blocked outside break");

  two_step_a: assert property (@(posedge mclk) disable iff (srst)
    two_step_clear
    |-> flag_clear_allow && two_step_armed_ff)
    else $error("two-step clear without armed first step");

  wait_stay_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_WAIT && !wake && !reset_event
    |=> pmode_ff == silp_pkg::PM_WAIT)
    else $error("wait left without interrupt or reset");

  stop_stay_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_STOP && !wake && !reset_event
    |=> pmode_ff == silp_pkg::PM_STOP)
    else $error("stop left without interrupt or reset");

  wait_clk_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_WAIT
    |-> !cpu_clk_en && periph_clk_en)
    else $error("wait clock gating wrong");

  wait_stack_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_WAIT && |irq_req && !reset_event
    |-> stacking_start)
    else $error("wait wake did not start stacking");

  wdog_wait_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_WAIT
    |-> watchdog_run == !watchdog_disable)
    else $error("watchdog state wrong in wait");

  stop_gate_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_STOP
    |-> !cpu_clk_en && !periph_clk_en && osc_en == oscillator_run_in_stop)
    else $error("stop clock gating wrong");

  short_pick_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_STOP && wake && !reset_event && short_stop_recovery
    |=> target_ff == silp_pkg::CNT_W'(SHORT_CYCLES))
    else $error("short recovery not selected");

  long_pick_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_STOP && wake && !reset_event && !short_stop_recovery
    |=> target_ff == silp_pkg::CNT_W'(LONG_CYCLES))
    else $error("long recovery not selected");

  early_stack_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_RECOVER && !recover_done
    |-> !stacking_start)
    else $error("stacking before recovery elapsed");

  rec_done_a: assert property (@(posedge mclk) disable iff (srst)
    recover_done
    |=> pmode_ff == silp_pkg::PM_RUN)
    else $error("recovery did not end in run");

  rec_count_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_RECOVER && !recover_done
    |=> pmode_ff == silp_pkg::PM_RECOVER && cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("recovery counter did not advance");

  wake_flag_a: assert property (@(posedge mclk) disable iff (srst)
    pmode_ff == silp_pkg::PM_WAIT && break_req
    |=> break_wake_flag_ff)
    else $error("break wake flag not set");

  wdog_cause_a: assert property (@(posedge mclk) disable iff (srst)
    reset_event && reset_cause_in.wdog
    |=> cause_ff.wdog)
    else $error("watchdog cause not flagged");

  lvi_cause_a: assert property (@(posedge mclk) disable iff (srst)
    reset_event && reset_cause_in.low_voltage
    |=> cause_ff.low_voltage)
    else $error("low-voltage cause not flagged");

  status1_a: assert property (@(posedge mclk) disable iff (srst)
    reg_req.addr == silp_pkg::ADDR_IRQ_STATUS_1
    |=> reg_rdata[7:2] == $past(irq_req[5:0]))
    else $error("irq status 1 does not track requests");

  status3_a: assert property (@(posedge mclk) disable iff (srst)
    reg_req.addr == silp_pkg::ADDR_IRQ_STATUS_3
    |=> reg_rdata[1:0] == $past(irq_req[15:14]))
    else $error("irq status 3 does not track requests");
endmodule : silp_core
`default_nettype wire

/* inc/silp_pkg.sv */
// Constants, register map and carrier types of the system integration unit.
// Assumes an 8-bit processor-side register port on the bus clock.
package silp_pkg;
  // ==========================================
  // Register addresses
  localparam logic [15:0] ADDR_BREAK_STATUS = 16'hfe00;
  localparam logic [15:0] ADDR_RESET_CAUSE = 16'hfe01;
  localparam logic [15:0] ADDR_BREAK_FLAG_CTRL = 16'hfe03;
  localparam logic [15:0] ADDR_IRQ_STATUS_1 = 16'hfe04;
  localparam logic [15:0] ADDR_IRQ_STATUS_2 = 16'hfe05;
  localparam logic [15:0] ADDR_IRQ_STATUS_3 = 16'hfe06;
  // ==========================================
  // Field positions
  localparam int BREAK_WAKE_BIT = 1;
  localparam int BREAK_CLEAR_EN_BIT = 7;
  localparam int IRQ_COUNT = 16;
  localparam int LOW_FLAG_SHIFT = 2;
  // Reset cause bit positions
  localparam int RC_POR = 7;
  localparam int RC_PIN = 6;
  localparam int RC_WDOG = 5;
  localparam int RC_OPCODE = 4;
  localparam int RC_ADDR = 3;
  localparam int RC_MONITOR = 1;
  localparam int RC_LVI = 0;
  // ==========================================
  // Stop recovery timing in crystal cycles
  localparam int LONG_RECOVERY = 4096;
  localparam int SHORT_RECOVERY = 32;
  localparam int CNT_W = 13;
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_WAIT = 2'b01,
    PM_STOP = 2'b11,
    PM_RECOVER = 2'b10
  } silp_pmode_e;

  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic bad_opcode;
    logic bad_fetch;
    logic monitor;
    logic low_voltage;
  } silp_rst_cause_s;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } silp_reg_req_s;
endpackage : silp_pkg

/* verif/silp_cpu_model.sv */
// Processor core model: runs low-power instructions, counts stacking starts.
// Assumes the bench asks for an instruction with a one-cycle go pulse.
`timescale 1ns/1ps
`default_nettype none
module silp_cpu_model (
  input wire logic mclk,
  input wire logic go_wait,
  input wire logic go_stop,
  input wire logic cpu_clk_en,
  input wire logic stacking_start,
  output logic wait_exec,
  output logic stop_exec,
  output int stacks
);
  // ==========================================
  // Instructions run only while clocked
  initial begin
    wait_exec = 1'b0;
    stop_exec = 1'b0;
    stacks = 0;
  end
  always @(posedge mclk) begin
    wait_exec <= go_wait && cpu_clk_en;
    stop_exec <= go_stop && cpu_clk_en;
    if (stacking_start === 1'b1) stacks <= stacks + 1;
  end
endmodule : silp_cpu_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench of the system integration core.
// Assumes silp_pkg and silp_core are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 0, srst = 1, break_req = 0, wait_go = 0, stop_go = 0, reset_event = 0;
  logic short_stop_recovery = 0, oscillator_run_in_stop = 0, watchdog_disable = 0;
  logic two_step_first = 0, two_step_second = 0, wait_exec, stop_exec;
  logic [15:0] irq_req = '0;
  silp_pkg::silp_reg_req_s reg_req = '0;
  silp_pkg::silp_rst_cause_s reset_cause_in = '0;
  logic [7:0] reg_rdata, d;
  logic cpu_clk_en, periph_clk_en, osc_en, clear_irq_mask, force_swi_vector;
  logic stacking_start, flag_clear_allow, two_step_clear, watchdog_run;
  logic [12:0] recovery_count;
  int miscompares = 0, checks = 0, stacks, n;
  logic [39:0] rows [6] = '{40'h0001_040000, 40'h0020_800000, 40'h0040_000100,
    40'h2000_008000, 40'h4000_000001, 40'hffff_fcff03};
  silp_core #(.LONG_CYCLES(64)) silp_core_i (.mclk, .srst, .reg_req, .reg_rdata,
    .irq_req, .break_req, .wait_exec, .stop_exec, .reset_event, .reset_cause_in,
    .short_stop_recovery, .oscillator_run_in_stop, .watchdog_disable, .two_step_first,
    .two_step_second, .cpu_clk_en, .periph_clk_en, .osc_en, .clear_irq_mask,
    .force_swi_vector, .stacking_start, .flag_clear_allow, .two_step_clear,
    .watchdog_run, .recovery_count);
  silp_cpu_model silp_cpu_model_i (.mclk, .go_wait(wait_go), .go_stop(stop_go),
    .cpu_clk_en, .stacking_start, .wait_exec, .stop_exec, .stacks);
  // ==========================================
  // Helpers
  initial forever #4 mclk = ~mclk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic rd(input logic [15:0] a);
    @(posedge mclk) reg_req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge mclk) reg_req <= '0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk) reg_req <= '{1'b1, 1'b1, a, v};
    @(posedge mclk) reg_req <= '0;
  endtask : wr
  task automatic ev(input logic [6:0] c);
    @(posedge mclk) reset_event <= 1'b1;
    reset_cause_in <= c;
    @(posedge mclk) reset_event <= 1'b0;
  endtask : ev
  task automatic wake(input int lim);
    @(posedge mclk) irq_req <= 16'h0001;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (stacking_start !== 1'b1 && n < lim);
    if (stacking_start !== 1'b1) begin
      miscompares++;
      summarize();
    end
    @(posedge mclk) irq_req <= '0;
  endtask : wake
  task automatic stop_run(input logic sh, input int t);
    @(posedge mclk) short_stop_recovery <= sh;
    stop_go <= 1'b1;
    @(posedge mclk) stop_go <= 1'b0;
    #1 chk(clear_irq_mask, 1);
    repeat (3) @(posedge mclk);
    #1 chk({cpu_clk_en, periph_clk_en, osc_en}, 0);
    chk(recovery_count, 0);
    wake(5000);
    chk(n >= t && n <= t + 3, 1);
  endtask : stop_run
  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd(16'hfe01);
    chk(d, 8'h00);
    foreach (rows[i]) begin
      @(posedge mclk) irq_req <= rows[i][39:24];
      for (int k = 0; k < 3; k++) begin
        rd(16'hfe04 + 16'(k));
        chk(d, rows[i][23-8*k -: 8]);
      end
    end
    wr(16'hfe04, 8'h00);
    rd(16'hfe04);
    chk(d, 8'hfc);
    @(posedge mclk) irq_req <= '0;
    ev(7'b0110000);
    rd(16'hfe01);
    chk(d, 8'h60);
    rd(16'hfe01);
    chk(d, 8'h00);
    ev(7'b0100000);
    ev(7'b1000000);
    rd(16'hfe01);
    chk(d, 8'h80);
    ev(7'b0001111);
    rd(16'hfe01);
    chk(d, 8'h1b);
    @(posedge mclk) break_req <= 1'b1;
    #1 chk(force_swi_vector, 1);
    chk(flag_clear_allow, 0);
    wr(16'hfe03, 8'h80);
    rd(16'hfe03);
    chk(d, 8'h80);
    chk(flag_clear_allow, 1);
    @(posedge mclk) reset_event <= 1'b1;
    reset_cause_in <= 7'b0100000;
    #1 chk(force_swi_vector, 0);
    @(posedge mclk) reset_event <= 1'b0;
    break_req <= 1'b0;
    wr(16'hfe03, 8'h00);
    @(posedge mclk) wait_go <= 1'b1;
    @(posedge mclk) wait_go <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({cpu_clk_en, periph_clk_en, watchdog_run}, 3'b011);
    wake(4);
    chk(n <= 3, 1);
    stop_run(1'b1, 32);
    stop_run(1'b0, 64);
    @(posedge mclk) oscillator_run_in_stop <= 1'b1;
    short_stop_recovery <= 1'b1;
    stop_go <= 1'b1;
    @(posedge mclk) stop_go <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(osc_en, 1);
    ev(7'b0100000);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 200);
    chk(n >= 64 && n <= 67, 1);
    @(posedge mclk) watchdog_disable <= 1'b1;
    wait_go <= 1'b1;
    @(posedge mclk) wait_go <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(watchdog_run, 0);
    @(posedge mclk) break_req <= 1'b1;
    @(posedge mclk) break_req <= 1'b0;
    rd(16'hfe00);
    chk(d, 8'h02);
    @(posedge mclk) two_step_first <= 1'b1;
    @(posedge mclk) two_step_first <= 1'b0;
    break_req <= 1'b1;
    two_step_second <= 1'b1;
    #1 chk(two_step_clear, 0);
    @(posedge mclk) break_req <= 1'b0;
    #1 chk(two_step_clear, 1);
    chk(flag_clear_allow, 1);
    @(posedge mclk) two_step_second <= 1'b0;
    #1 chk(two_step_clear, 0);
    wr(16'hfe03, 8'h80);
    @(posedge mclk) srst <= 1'b1;
    @(posedge mclk) srst <= 1'b0;
    rd(16'hfe03);
    chk(d, 8'h00);
    rd(16'hfe00);
    chk(d, 8'h00);
    chk(stacks, 3);
    summarize();
  end
endmodule : tb
`default_nettype wire
